// *** core/lane_cd_params.svh ***
// constants of the lane c/d configuration block: addresses, field positions, resets
// assumes inclusion by bare name from every core file that needs a figure
`ifndef LANE_CD_PARAMS_SVH
`define LANE_CD_PARAMS_SVH

// management register numbers of the two lane registers
`define LCD_ADDR_LANE_C 5'h13
`define LCD_ADDR_LANE_D 5'h14

// width of the stored part of a lane register (bits 15:11 are not stored)
`define LCD_STORE_W 11

// field positions inside a lane register and inside global register 16
`define LCD_MP_HI 10
`define LCD_MP_LO 9
`define LCD_LOSDET 8
`define LCD_CFG_HI 7
`define LCD_CFG_LO 6
`define LCD_EMPH_HI 5
`define LCD_EMPH_LO 4
`define LCD_LPBK 3
`define LCD_PRBS 2
`define LCD_ALIGN 1
`define LCD_PWRDN 0

// positions inside global control register 0
`define LCD_G0_LPBK 14
`define LCD_G0_PWRDN 11

// status word positions, lane c at the base, lane d one above
`define LCD_STAT_LOS_BASE 2
`define LCD_STAT_PRBS_BASE 6

// reset value of the stored lane field: detection and alignment enabled
`define LCD_CFG_RST 11'h102

`endif

// *** core/lane_cd_pkg.sv ***
// types shared by the lane c/d configuration block
// assumes nothing beyond a sv compiler; constants live in lane_cd_params.svh
package lane_cd_pkg;

    // source of the multifunction pin, in order of the select code
    typedef enum logic [1:0] {
        MP_IO_STD,
        MP_COMMA,
        MP_LOS,
        MP_PRBS
    } mp_sel_t;

    // management data word
    typedef logic [15:0] mgmt_word_t;

endpackage

// *** core/lane_cfg_slice.sv ***
// one lane configuration register with strap-guarded bits
// assumes writes arrive as single-cycle strobes already decoded for this lane
`timescale 1ns/1ps
`include "lane_cd_params.svh"

module lane_cfg_slice (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic wr_stb,
    input wire logic [15:0] wr_data,
    input wire logic strap_cfg_hi,
    input wire logic strap_cfg_lo,
    input wire logic selftest_pattern_pin,
    output logic [`LCD_STORE_W-1:0] cfg_q
);

    logic [`LCD_STORE_W-1:0] cfg_r; // stored low field of the register
    logic [`LCD_STORE_W-1:0] cfg_nxt; // value after this cycle
    logic [`LCD_STORE_W-1:0] keep_mask; // bits frozen by a high strap

    // a high strap freezes its bit against management writes
    always_comb begin
        keep_mask = '0;
        keep_mask[`LCD_CFG_HI] = strap_cfg_hi;
        keep_mask[`LCD_CFG_LO] = strap_cfg_lo;
        keep_mask[`LCD_PRBS] = selftest_pattern_pin;
        cfg_nxt = cfg_r;
        if (wr_stb) begin
            // upper bits are simply not stored
            cfg_nxt = (cfg_r & keep_mask) | (wr_data[`LCD_STORE_W-1:0] & ~keep_mask);
        end
    end

    // storage with documented reset values
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= `LCD_CFG_RST;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    assign cfg_q = cfg_r;

endmodule

// *** core/lane_cd_config_registers.sv ***
// configuration registers of lanes c and d with their merged lane controls
// assumes a management front end that turns frames into register strobes,
// and outer logic that owns global registers 0 and 16 and status register 22
//
// Behaviour
// - bits 15:11 read zero, writes dropped
// - lane c select 00 io standard, 01 comma
// - lane c select 10 los, 11 prbs pass
// - lane d same, status bits three and seven
// - pin select ORed with global bits 10:9
// - bit 8 los detect, reset one, ANDed
// - bit 7 ORed with strap and global
// - bit 6 ORed with strap and global
// - config bits frozen while their strap high
// - bits 5:4 emphasis ORed with global
// - bit 3 loopback ORed with control 0.14
// - bit 2 prbs ORed with global 16.2
// - prbs bit frozen while selftest pin high
// - bit 1 alignment, reset one, triple AND
// - bit 0 power down ORed with 0.11
// - lane d loopback identical to lane c
// - los status cleared after status read
// - prbs pass resets one, read restores one
// - loopback routes tx to rx, output released
//
// notes for the next engineer
// a status event in the cycle of a status read wins,
// so a loss of signal is never dropped between two reads
// strap pins are sampled in the write cycle itself; a strap
// that rises later leaves the stored bit as it was
// read data is taken on the read strobe and then holds, so a
// slow station may pick it up any time before its next read
// merged controls are gates only: no extra cycle of latency
// the serial driver is released in loopback and in power down,
// and the receiver pin is ignored while loopback is on
// lane numbering: index 0 is lane c, index 1 is lane d; the
// address table and the two pin outputs assume two lanes
`timescale 1ns/1ps
`include "lane_cd_params.svh"

module lane_cd_config_registers #(
    parameter int LANES = 2
) (
    // clock and asynchronous reset
    input wire logic sys_clk,
    input wire logic arst_n,

    // management register access
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr_en,
    input wire logic [15:0] mgmt_wr_data,
    input wire logic mgmt_rd_en,
    output logic [15:0] mgmt_rd_data,
    output logic mgmt_rd_valid,

    // read of status register 22 by the management side
    input wire logic stat_rd_pulse,

    // global registers held elsewhere
    input wire logic [15:0] glob_cfg,
    input wire logic [15:0] glob_ctrl,

    // device pins shared by both lanes
    input wire logic strap_cfg_hi,
    input wire logic strap_cfg_lo,
    input wire logic selftest_pattern_pin,
    input wire logic align_enable_pin,
    input wire logic io_std_hstl,

    // per-lane datapath events, index 0 is lane c, 1 is lane d
    input wire logic [LANES-1:0] comma_det,
    input wire logic [LANES-1:0] los_event,
    input wire logic [LANES-1:0] prbs_err,

    // per-lane serial path around the loopback switch
    input wire logic [LANES-1:0] ser_tx,
    input wire logic [LANES-1:0] ser_rx_pin,
    output logic [LANES-1:0] ser_out,
    output logic [LANES-1:0] ser_out_oe,
    output logic [LANES-1:0] rx_to_core,

    // multifunction pins
    output logic lane_c_multipin,
    output logic lane_d_multipin,

    // merged lane controls
    output logic [LANES-1:0] los_det_en,
    output logic [LANES-1:0] cfg_hi_eff,
    output logic [LANES-1:0] cfg_lo_eff,
    output logic [LANES-1:0] emphasis_hi,
    output logic [LANES-1:0] emphasis_lo,
    output logic [LANES-1:0] loopback_eff,
    output logic [LANES-1:0] prbs_eff,
    output logic [LANES-1:0] align_eff,
    output logic [LANES-1:0] pwrdn_eff,

    // lane c/d share of status register 22, other bits zero
    output logic [15:0] stat_cd_bits
);

    // stored fields of every lane
    logic [`LCD_STORE_W-1:0] cfg_q [LANES];

    // per-lane write strobes
    logic [LANES-1:0] wr_stb;
    // per-lane read selects
    logic [LANES-1:0] rd_hit;

    // sticky loss-of-signal status
    logic [LANES-1:0] los_flag;
    // prbs pass status
    logic [LANES-1:0] prbs_pass;
    // multifunction pin value per lane
    logic [LANES-1:0] mp_pin;

    // read word assembled from the hit lane
    logic [15:0] rd_word;
    // register numbers of the lanes, in lane order
    logic [4:0] lane_addr [LANES];

    // register numbers, lane c first
    // only two lanes are mapped; more lanes need more entries
    always_comb begin
        lane_addr[0] = `LCD_ADDR_LANE_C;
        lane_addr[1] = `LCD_ADDR_LANE_D;
    end

    // pick the multifunction pin source from the merged select code
    function automatic logic mp_pick(
        input lane_cd_pkg::mp_sel_t sel,
        input logic hstl,
        input logic comma,
        input logic signal_lost,
        input logic pass
    );
        logic val;
        val = 1'b0;
        case (sel)
            // high for hstl, low for sstl
            lane_cd_pkg::MP_IO_STD: val = hstl;
            // high on comma, low on data
            lane_cd_pkg::MP_COMMA: val = comma;
            // sticky loss-of-signal status
            lane_cd_pkg::MP_LOS: val = signal_lost;
            // prbs pass status
            lane_cd_pkg::MP_PRBS: val = pass;
            // the code is fully decoded; this only guards unknowns
            default: val = 1'b0;
        endcase
        return val;
    endfunction

    // per-lane registers, merges, status and loopback switch
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            // per-lane local state
            logic los_r; // loss of signal seen since last status read
            logic los_nxt; // its next value
            logic pass_r; // no prbs error since last status read
            logic pass_nxt; // its next value
            logic [1:0] sel_bits; // merged select code
            lane_cd_pkg::mp_sel_t sel; // merged select as a type

            // address decode for writes and reads of this lane
            assign wr_stb[gi] = mgmt_wr_en && (mgmt_addr == lane_addr[gi]);
            // a read hit needs no strobe; the word is only taken on one
            assign rd_hit[gi] = (mgmt_addr == lane_addr[gi]);

            // register storage with strap guards
            // strap pins are shared by both lanes
            lane_cfg_slice u_slice (
                .sys_clk(sys_clk),
                .arst_n(arst_n),
                .wr_stb(wr_stb[gi]),
                .wr_data(mgmt_wr_data),
                .strap_cfg_hi(strap_cfg_hi),
                .strap_cfg_lo(strap_cfg_lo),
                .selftest_pattern_pin(selftest_pattern_pin),
                .cfg_q(cfg_q[gi])
            );

            // merged controls are plain gates on the stored fields
            // so they move in the cycle after the write strobe

            // detection needs both the lane and the global enable
            assign los_det_en[gi] = cfg_q[gi][`LCD_LOSDET]
                & glob_cfg[`LCD_LOSDET];

            // configuration bits: lane bit, strap pin or global bit
            assign cfg_hi_eff[gi] = cfg_q[gi][`LCD_CFG_HI] | strap_cfg_hi
                | glob_cfg[`LCD_CFG_HI];
            assign cfg_lo_eff[gi] = cfg_q[gi][`LCD_CFG_LO] | strap_cfg_lo
                | glob_cfg[`LCD_CFG_LO];

            // emphasis pair, each ORed with its own global bit
            assign emphasis_hi[gi] = cfg_q[gi][`LCD_EMPH_HI]
                | glob_cfg[`LCD_EMPH_HI];
            assign emphasis_lo[gi] = cfg_q[gi][`LCD_EMPH_LO]
                | glob_cfg[`LCD_EMPH_LO];

            // both lanes use the same global loopback bit
            assign loopback_eff[gi] = cfg_q[gi][`LCD_LPBK]
                | glob_ctrl[`LCD_G0_LPBK];

            // self-test mode: lane bit or global bit, pin not merged
            assign prbs_eff[gi] = cfg_q[gi][`LCD_PRBS]
                | glob_cfg[`LCD_PRBS];

            // alignment needs the lane bit, the pin and the global bit
            assign align_eff[gi] = cfg_q[gi][`LCD_ALIGN] & align_enable_pin
                & glob_cfg[`LCD_ALIGN];

            // power down: lane bit or global control bit
            assign pwrdn_eff[gi] = cfg_q[gi][`LCD_PWRDN]
                | glob_ctrl[`LCD_G0_PWRDN];

            // multifunction select merged with the global code
            assign sel_bits = cfg_q[gi][`LCD_MP_HI:`LCD_MP_LO]
                | glob_cfg[`LCD_MP_HI:`LCD_MP_LO];
            // cast to the select type so the decode reads by name
            assign sel = lane_cd_pkg::mp_sel_t'(sel_bits);
            assign mp_pin[gi] = mp_pick(sel, io_std_hstl, comma_det[gi],
                los_r, pass_r);

            // loss of signal: a new event beats the read clear
            always_comb begin
                // default: hold the flag
                los_nxt = los_r;
                if (los_event[gi] && los_det_en[gi]) begin
                    // event only counts while detection is enabled
                    los_nxt = 1'b1;
                end else if (stat_rd_pulse) begin
                    // status read clears it
                    los_nxt = 1'b0;
                end
            end

            // loss-of-signal flag storage
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    // no loss seen after reset
                    los_r <= 1'b0;
                end else begin
                    // follow the set and clear logic
                    los_r <= los_nxt;
                end
            end

            // prbs pass: an error beats the read restore
            always_comb begin
                // default: hold the flag
                pass_nxt = pass_r;
                if (prbs_err[gi] && prbs_eff[gi]) begin
                    // errors only count in prbs mode
                    pass_nxt = 1'b0;
                end else if (stat_rd_pulse) begin
                    // status read restores pass
                    pass_nxt = 1'b1;
                end
            end

            // prbs pass storage, passing after reset
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    // passing until an error is seen
                    pass_r <= 1'b1;
                end else begin
                    // follow the error and restore logic
                    pass_r <= pass_nxt;
                end
            end

            assign los_flag[gi] = los_r;
            assign prbs_pass[gi] = pass_r;

            // loopback turns tx back into the receiver
            assign rx_to_core[gi] = loopback_eff[gi] ? ser_tx[gi]
                : ser_rx_pin[gi];

            // serial output released in loopback and lane power down
            assign ser_out_oe[gi] = !loopback_eff[gi] && !pwrdn_eff[gi];

            // output data parked low while released
            assign ser_out[gi] = ser_out_oe[gi] ? ser_tx[gi] : 1'b0;
        end
    endgenerate

    // multifunction pins by lane
    // lane c takes index 0, lane d index 1
    assign lane_c_multipin = mp_pin[0];
    assign lane_d_multipin = mp_pin[1];

    // status bits placed at their word positions
    // lane c sits at the base bit, lane d one above it
    always_comb begin
        // bits of other lanes and fields stay zero here
        stat_cd_bits = '0;
        for (int i = 0; i < LANES; i++) begin
            // sticky loss of signal
            stat_cd_bits[`LCD_STAT_LOS_BASE + i] = los_flag[i];
            // prbs pass
            stat_cd_bits[`LCD_STAT_PRBS_BASE + i] = prbs_pass[i];
        end
    end

    // read word: hit lane's field, reserved bits zero, unmapped reads zero
    // decode is a priority chain, lane c first
    always_comb begin
        rd_word = '0;
        if (rd_hit[0]) begin
            // lane c register
            rd_word[`LCD_STORE_W-1:0] = cfg_q[0];
        end else if (rd_hit[1]) begin
            // lane d register
            rd_word[`LCD_STORE_W-1:0] = cfg_q[1];
        end else begin
            // any other number answers zero
            rd_word = '0;
        end
    end

    // read data captured on the read strobe
    // the word then holds until the next read strobe
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            // nothing read yet
            mgmt_rd_data <= 16'h0000;
        end else if (mgmt_rd_en) begin
            // sample the addressed word
            mgmt_rd_data <= rd_word;
        end
    end

    // read valid one cycle after the strobe
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            // no answer pending
            mgmt_rd_valid <= 1'b0;
        end else begin
            // follows the strobe by exactly one cycle
            mgmt_rd_valid <= mgmt_rd_en;
        end
    end

endmodule

// *** tb/lane_cd_properties.sv ***
// port assertions of the lane c/d configuration registers
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module lane_cd_properties #(parameter int LANES = 2) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic mgmt_rd_en,
    input wire logic mgmt_rd_valid,
    input wire logic strap_cfg_hi,
    input wire logic align_enable_pin,
    input wire logic lane_c_multipin,
    input wire logic lane_d_multipin,
    input wire logic stat_rd_pulse,
    input wire logic [15:0] mgmt_rd_data,
    input wire logic [15:0] glob_cfg,
    input wire logic [15:0] glob_ctrl,
    input wire logic [15:0] stat_cd_bits,
    input wire logic [LANES-1:0] los_event,
    input wire logic [LANES-1:0] prbs_err,
    input wire logic [LANES-1:0] ser_tx,
    input wire logic [LANES-1:0] ser_out_oe,
    input wire logic [LANES-1:0] rx_to_core,
    input wire logic [LANES-1:0] los_det_en,
    input wire logic [LANES-1:0] cfg_hi_eff,
    input wire logic [LANES-1:0] loopback_eff,
    input wire logic [LANES-1:0] prbs_eff,
    input wire logic [LANES-1:0] align_eff,
    input wire logic [LANES-1:0] pwrdn_eff
);
    // all checks on the rising edge, off during reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_rd_lat; 1'b1 |=> mgmt_rd_valid == $past(mgmt_rd_en); endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer not one cycle");
    property p_resv; mgmt_rd_valid |-> mgmt_rd_data[15:11] == 5'h00; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    property p_loop; glob_ctrl[14] |-> &loopback_eff; endproperty
    a_loop: assert property (p_loop) else $error("loopback merge lost");
    property p_pwr; glob_ctrl[11] |-> &pwrdn_eff; endproperty
    a_pwr: assert property (p_pwr) else $error("power down merge lost");
    property p_losen; !glob_cfg[8] |-> los_det_en == 2'h0; endproperty
    a_losen: assert property (p_losen) else $error("detect enable not anded");
    property p_align; !(align_enable_pin && glob_cfg[1]) |-> align_eff == 2'h0; endproperty
    a_align: assert property (p_align) else $error("alignment not anded");
    property p_strap; strap_cfg_hi |-> &cfg_hi_eff; endproperty
    a_strap: assert property (p_strap) else $error("strap not ored");
    property p_prbs; glob_cfg[2] |-> &prbs_eff; endproperty
    a_prbs: assert property (p_prbs) else $error("self test merge lost");
    property p_lpath; loopback_eff[0] |-> !ser_out_oe[0] && rx_to_core[0] == ser_tx[0]; endproperty
    a_lpath: assert property (p_lpath) else $error("loopback path wrong");
    property p_los; los_event[1] && los_det_en[1] |=> stat_cd_bits[3]; endproperty
    a_los: assert property (p_los) else $error("lost flag not set");
    property p_pass; prbs_err[1] && prbs_eff[1] |=> !stat_cd_bits[7]; endproperty
    a_pass: assert property (p_pass) else $error("pass flag not cleared");
    property p_clear; stat_rd_pulse && !los_event && !prbs_err |=> stat_cd_bits == 16'h00C0;
    endproperty
    a_clear: assert property (p_clear) else $error("status read not restoring");
    property p_mp; glob_cfg[10:9] == 2'h3 |-> lane_c_multipin == stat_cd_bits[6]
        && lane_d_multipin == stat_cd_bits[7]; endproperty
    a_mp: assert property (p_mp) else $error("pin select merge wrong");
endmodule
bind lane_cd_config_registers lane_cd_properties #(.LANES(LANES)) lane_cd_properties_i (
    .sys_clk, .arst_n, .mgmt_rd_en, .mgmt_rd_valid, .strap_cfg_hi, .align_enable_pin,
    .lane_c_multipin, .lane_d_multipin, .stat_rd_pulse, .mgmt_rd_data, .glob_cfg,
    .glob_ctrl, .stat_cd_bits, .los_event, .prbs_err, .ser_tx, .ser_out_oe, .rx_to_core,
    .los_det_en, .cfg_hi_eff, .loopback_eff, .prbs_eff, .align_eff, .pwrdn_eff);

// *** tb/mgmt_station.sv ***
// management station model issuing register strobes
// assumes strobes are taken on the rising edge between two falling edges
`timescale 1ns/1ps
module mgmt_station (
    input wire logic sys_clk,
    output logic [4:0] mgmt_addr,
    output logic mgmt_wr_en,
    output logic [15:0] mgmt_wr_data,
    output logic mgmt_rd_en,
    input wire logic [15:0] mgmt_rd_data,
    input wire logic mgmt_rd_valid
);
    // idle bus at time zero
    initial begin
        {mgmt_addr, mgmt_wr_en, mgmt_wr_data, mgmt_rd_en} = 23'h000000;
    end
    // one write strobe carrying a whole 16-bit word
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        {mgmt_addr, mgmt_wr_data, mgmt_wr_en} = {a, d, 1'b1};
        @(negedge sys_clk);
        // released data shows the inverse, not the last value
        {mgmt_wr_data, mgmt_wr_en} = {~d, 1'b0};
    endtask
    // read strobe; the answer stands in the following cycle
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(negedge sys_clk);
        {mgmt_addr, mgmt_rd_en} = {a, 1'b1};
        @(negedge sys_clk);
        mgmt_rd_en = 1'b0;
        ok = mgmt_rd_valid;
        d = mgmt_rd_data;
    endtask
endmodule

// *** tb/lane_cd_config_registers_tb.sv ***
// self-checking bench of the lane c/d configuration registers
// assumes the station model makes every management access
`timescale 1ns/1ps
`include "lane_cd_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); num_errors++; end end
module lane_cd_config_registers_tb;
    int num_errors = 0; // mismatches
    int num_checks = 0; // comparisons
    logic sys_clk, arst_n, stat_rd_pulse, strap_cfg_hi, strap_cfg_lo, rok;
    logic selftest_pattern_pin, align_enable_pin, io_std_hstl, lane_c_multipin, lane_d_multipin;
    logic [15:0] glob_cfg, glob_ctrl, mgmt_wr_data, mgmt_rd_data, stat_cd_bits, rdat;
    logic [4:0] mgmt_addr;
    logic mgmt_wr_en, mgmt_rd_en, mgmt_rd_valid;
    logic [1:0] comma_det, los_event, prbs_err, ser_tx, ser_rx_pin, ser_out, ser_out_oe;
    logic [1:0] rx_to_core, los_det_en, cfg_hi_eff, cfg_lo_eff, emphasis_hi, emphasis_lo;
    logic [1:0] loopback_eff, prbs_eff, align_eff, pwrdn_eff;
    logic [17:0] eff; // all merged controls, lane d above lane c
    assign eff = {los_det_en, cfg_hi_eff, cfg_lo_eff, emphasis_hi, emphasis_lo,
        loopback_eff, prbs_eff, align_eff, pwrdn_eff};
    lane_cd_config_registers #(.LANES(2)) lane_cd_config_registers_i (
        .sys_clk, .arst_n, .mgmt_addr, .mgmt_wr_en, .mgmt_wr_data, .mgmt_rd_en,
        .mgmt_rd_data, .mgmt_rd_valid, .stat_rd_pulse, .glob_cfg, .glob_ctrl,
        .strap_cfg_hi, .strap_cfg_lo, .selftest_pattern_pin, .align_enable_pin,
        .io_std_hstl, .comma_det, .los_event, .prbs_err, .ser_tx, .ser_rx_pin,
        .ser_out, .ser_out_oe, .rx_to_core, .lane_c_multipin, .lane_d_multipin,
        .los_det_en, .cfg_hi_eff, .cfg_lo_eff, .emphasis_hi, .emphasis_lo,
        .loopback_eff, .prbs_eff, .align_eff, .pwrdn_eff, .stat_cd_bits);
    mgmt_station mgmt_station_i (.sys_clk, .mgmt_addr, .mgmt_wr_en, .mgmt_wr_data,
        .mgmt_rd_en, .mgmt_rd_data, .mgmt_rd_valid);
    // read and compare one register word
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        mgmt_station_i.rd(a, rdat, rok);
        `CHK("rd_valid", 1'b1, rok)
        `CHK("rd_data", e, rdat)
    endtask
    // one-cycle pulse of datapath events and status read
    task automatic pulse(input logic [1:0] l, input logic [1:0] p, input logic s);
        @(negedge sys_clk);
        {los_event, prbs_err, stat_rd_pulse} = {l, p, s};
        @(negedge sys_clk);
        {los_event, prbs_err, stat_rd_pulse} = 5'h00;
    endtask
    // reset words and an unmapped number
    task automatic t_reset();
        rd_chk(`LCD_ADDR_LANE_C, 16'h0102);
        rd_chk(`LCD_ADDR_LANE_D, 16'h0102);
        rd_chk(5'h15, 16'h0000);
        `CHK("stat", 16'h00C0, stat_cd_bits)
        $display("test reset done");
    endtask
    // every field set, reserved bits dropped, loopback path
    task automatic t_fields();
        mgmt_station_i.wr(`LCD_ADDR_LANE_C, 16'hFFFF);
        `CHK("eff", 18'h3555D, eff)
        `CHK("serial", 6'h29, {ser_out, ser_out_oe, rx_to_core})
        rd_chk(`LCD_ADDR_LANE_C, 16'h07FF);
        mgmt_station_i.wr(`LCD_ADDR_LANE_C, 16'h0000);
        mgmt_station_i.wr(`LCD_ADDR_LANE_D, 16'h0108);
        `CHK("loop_d", 2'h2, loopback_eff)
        glob_ctrl = 16'h4000;
        @(negedge sys_clk);
        `CHK("loop_g", 2'h3, loopback_eff)
        glob_ctrl = 16'h0000;
        $display("test fields done");
    endtask
    // strap-guarded bits frozen while their pin is high
    task automatic t_freeze();
        {strap_cfg_hi, strap_cfg_lo, selftest_pattern_pin} = 3'h7;
        mgmt_station_i.wr(`LCD_ADDR_LANE_C, 16'h00C4);
        rd_chk(`LCD_ADDR_LANE_C, 16'h0000);
        {strap_cfg_hi, strap_cfg_lo, selftest_pattern_pin} = 3'h0;
        mgmt_station_i.wr(`LCD_ADDR_LANE_C, 16'h00C4);
        rd_chk(`LCD_ADDR_LANE_C, 16'h00C4);
        {strap_cfg_hi, strap_cfg_lo, selftest_pattern_pin} = 3'h7;
        mgmt_station_i.wr(`LCD_ADDR_LANE_C, 16'h0000);
        rd_chk(`LCD_ADDR_LANE_C, 16'h00C4);
        {strap_cfg_hi, strap_cfg_lo, selftest_pattern_pin} = 3'h0;
        mgmt_station_i.wr(`LCD_ADDR_LANE_C, 16'h0000);
        $display("test freeze done");
    endtask
    // status flags and every pin select code on lane d
    task automatic t_status();
        glob_cfg = 16'h0100;
        mgmt_station_i.wr(`LCD_ADDR_LANE_D, 16'h0104);
        pulse(2'h3, 2'h3, 1'b0);
        `CHK("stat_ev", 16'h0048, stat_cd_bits)
        {io_std_hstl, comma_det} = 3'h2;
        for (int s = 0; s < 4; s++) begin
            mgmt_station_i.wr(`LCD_ADDR_LANE_D, {5'h00, 2'(s), 9'h104});
            `CHK("pin_d", 4'h6 >> s & 4'h1, 4'(lane_d_multipin))
        end
        mgmt_station_i.wr(`LCD_ADDR_LANE_C, 16'h0000);
        glob_cfg = 16'h0700;
        @(negedge sys_clk);
        `CHK("pin_or", 2'h2, {lane_c_multipin, lane_d_multipin})
        pulse(2'h0, 2'h0, 1'b1);
        `CHK("stat_rd", 16'h00C0, stat_cd_bits)
        $display("test status done");
    endtask
    // global register and pin merges
    task automatic t_globals();
        {glob_cfg, glob_ctrl, strap_cfg_hi, align_enable_pin} = {16'h0026, 16'h4800, 2'h2};
        @(negedge sys_clk);
        `CHK("eff_g", 18'h0CCF3, eff)
        // mid-run reset brings back the reset words
        arst_n = 1'b0;
        @(negedge sys_clk);
        arst_n = 1'b1;
        rd_chk(`LCD_ADDR_LANE_C, 16'h0102);
        rd_chk(`LCD_ADDR_LANE_D, 16'h0102);
        $display("test globals done");
    endtask
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // hang guard, far beyond the roughly 55 cycles needed
    initial begin
        #20000;
        num_errors++;
        finish_test();
    end
    // reset for two cycles, then the tests
    initial begin
        {arst_n, stat_rd_pulse, strap_cfg_hi, strap_cfg_lo, selftest_pattern_pin} = 5'h00;
        {align_enable_pin, io_std_hstl, glob_cfg, glob_ctrl} = {2'h2, 16'h0102, 16'h0000};
        {comma_det, los_event, prbs_err, ser_tx, ser_rx_pin} = 10'h00C;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset();
        t_fields();
        t_freeze();
        t_status();
        t_globals();
        finish_test();
    end
endmodule
